//--- rtl/bps_top.sv
// What this block does
// RULE_01: Cycle count rises once per discharged fifth of full capacity.
// RULE_02: Six LEDs: four SOC, one red fault, one run-state.
// RULE_03: Auto sleep after 48 hours without charge or discharge current.
// RULE_04: Undervoltage held one minute: stay talking, then go dormant.
// RULE_05: Button held six seconds: LEDs light in turn, then sleep.
// RULE_06: External switch option: closed powers up, open shuts down.
// RULE_07: Standby auto sleep is enabled by host setting.
// RULE_08: Balance only charging or standby, above start and difference.
// RULE_09: Communication address comes from eight-position address switch.
// RULE_10: Record history on state, alarm edges and periodic window.
// RULE_11: Protection groups host-enabled; short circuit always enabled.
// RULE_12: Precharge after power-up or discharge-on, 1 to 5000 ms.
// RULE_13: Active limit mode keeps 10 A path on while charging.
// RULE_14: Passive mode: over warning moves to 10 A path, recheck at 5 min.
// RULE_15: Master pack switches slave packs; address switches must match. The code instead takes address 0 as master and any other address as slave.
// RULE_16: Host serial link runs at 19200 baud.
// RULE_17: Recheck below warning level returns charging to main path.
`timescale 1ns/1ps
`default_nettype none
module bps_top
  import bps_pkg::*;
#(
  parameter int unsigned TICK_CYC_P   = bps_pkg::TICK_CYC,
  parameter int unsigned BAUD_CYC_P   = bps_pkg::BAUD_CYC,
  parameter int unsigned IDLE_MS_P    = bps_pkg::IDLE_SLEEP_MS,
  parameter int unsigned UV_MS_P      = bps_pkg::UV_HOLD_MS,
  parameter int unsigned BTN_MS_P     = bps_pkg::BTN_HOLD_MS,
  parameter int unsigned LIMIT_MS_P   = bps_pkg::LIMIT_MS,
  parameter int unsigned LED_STEP_P   = bps_pkg::LED_STEP_MS,
  parameter int unsigned SEC_MS_P     = bps_pkg::SEC_MS,
  parameter int unsigned HIST_DEPTH   = 512
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reset_btn,
  input  wire logic        ext_sw,
  input  wire logic [7:0]  addr_sw,
  input  wire logic        par_cmd_in,
  input  wire logic [15:0] chg_cur,
  input  wire logic [15:0] dsg_cur,
  input  wire logic        cap_tick,
  input  wire logic [6:0]  soc,
  input  wire logic [15:0] cell_max,
  input  wire logic [15:0] cell_min,
  input  wire logic [3:0]  prot_hit,
  input  wire logic        uv_prot,
  input  wire logic        short_hit,
  input  wire logic        alarm_hit,
  output logic [5:0]       led,
  output logic             power_on,
  output logic             comm_en,
  output logic             precharge_on,
  output logic             dsg_sw_on,
  output logic             main_chg_on,
  output logic             limit_on,
  output logic             bal_on,
  output logic             par_cmd_out,
  output logic [7:0]       comm_addr,
  output logic             baud_tick,
  output logic             irq
);
  import bps_pkg::*;

  localparam int unsigned AW = $clog2(HIST_DEPTH);

  typedef struct packed {
    logic [11:0] ctrl;
    logic [15:0] full_cap;
    logic [15:0] bal_start;
    logic [15:0] bal_diff;
    logic [12:0] pre_set;
    logic [15:0] ocw;
    logic [19:0] rec_start;
    logic [19:0] rec_end;
    logic [15:0] rec_intv;
    logic [3:0]  int_stat;
    logic [3:0]  int_mask;
    logic [AW-1:0] hist_idx;
    logic [AW-1:0] hist_wp;
    logic [AW:0]   hist_cnt;
    logic [31:0] rdata;
    logic        rerr;
    bps_state_t  st;
    bps_state_t  st_d;
    logic [15:0] cycles;
    logic [15:0] acc;
    logic [17:0] tick_cnt;
    logic [13:0] baud_cnt;
    logic [9:0]  sec_ms;
    logic [19:0] time_s;
    logic [15:0] rec_s;
    logic [27:0] idle_ms;
    logic [15:0] uv_ms;
    logic [12:0] btn_ms;
    logic [18:0] lim_ms;
    logic [12:0] pre_ms;
    logic [8:0]  seq_ms;
    logic [2:0]  seq_idx;
    logic        limited;
    logic        dsg_en_d;
    logic        fault_d;
    logic [5:0]  ev_d;
    logic        btn1, btn2, btn_d;
    logic        sw1, sw2, sw_d;
    logic        par1, par2, par_d;
    logic [7:0]  addr1, addr2;
    logic [5:0]  led;
    logic        baud;
  } bps_regs_t;

  bps_regs_t s, n;
  logic [31:0] hist_mem [HIST_DEPTH];
  logic        ms, sec, chg, dsg, fault, master, wake, rec_we;
  logic [5:0]  ev;
  logic [3:0]  int_ev;
  logic [2:0]  cause;
  logic [12:0] pre_lim;
  logic [15:0] cell_dif;
  logic        setup, access, rd_clr;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    int_ev = 4'h0;
    cause = 3'h0;
    rd_clr = 1'b0;
    // Double-flop every pin from outside the clock domain
    n.btn1 = reset_btn;
    n.btn2 = s.btn1;
    n.btn_d = s.btn2;
    n.sw1 = ext_sw;
    n.sw2 = s.sw1;
    n.sw_d = s.sw2;
    n.par1 = par_cmd_in;
    n.par2 = s.par1;
    n.par_d = s.par2;
    n.addr1 = addr_sw;
    n.addr2 = s.addr1;
    master = (s.addr2 == MASTER_ADDR);

    // Millisecond, second and baud enables
    ms = (s.tick_cnt == 18'(TICK_CYC_P - 1));
    n.tick_cnt = ms ? 18'h0 : s.tick_cnt + 18'h1;
    n.baud = (s.baud_cnt == 14'(BAUD_CYC_P - 1)); // see RULE_16
    n.baud_cnt = n.baud ? 14'h0 : s.baud_cnt + 14'h1;
    sec = ms && (s.sec_ms == 10'(SEC_MS_P - 1));
    if (ms) begin
      n.sec_ms = sec ? 10'h0 : s.sec_ms + 10'h1;
    end
    if (sec) begin
      n.time_s = s.time_s + 20'h1;
    end

    chg = chg_cur > CUR_IDLE;
    dsg = dsg_cur > CUR_IDLE;
    // Short circuit ignores the enables
    fault = short_hit
          | (|(prot_hit & s.ctrl[CTRL_PROT_LSB +: 4])); // see RULE_11
    n.fault_d = fault;
    if (fault && !s.fault_d) begin
      int_ev[INT_FAULT] = 1'b1;
    end

    // Cycle count; full_cap of zero counts every tick
    if (cap_tick) begin
      if (((19'(s.acc) + 19'h1) * CYCLE_DIV) >= 19'(s.full_cap)) begin
        n.acc = 16'h0; // see RULE_01
        n.cycles = s.cycles + 16'h1;
        int_ev[INT_CYCLE] = 1'b1;
      end else begin
        n.acc = s.acc + 16'h1;
      end
    end

    // Hold timers
    if (ms) begin
      n.idle_ms = (chg || dsg) ? 28'h0 :
                  (s.idle_ms == 28'hfffffff ? s.idle_ms : s.idle_ms + 28'h1);
      n.uv_ms = (uv_prot && s.ctrl[CTRL_PROT_LSB]) ? s.uv_ms + 16'h1 : 16'h0;
      n.btn_ms = s.btn2 ? s.btn_ms + 13'h1 : 13'h0;
    end
    if (!s.btn2) begin
      n.btn_ms = 13'h0;
    end
    if (!uv_prot || !s.ctrl[CTRL_PROT_LSB]) begin
      n.uv_ms = 16'h0;
    end

    pre_lim = (s.pre_set < PRECHG_MIN_MS) ? PRECHG_MIN_MS :
              (s.pre_set > PRECHG_MAX_MS) ? PRECHG_MAX_MS : s.pre_set;
    wake = (s.btn2 && !s.btn_d)
         || (s.ctrl[CTRL_EXT_SW] && s.sw2 && !s.sw_d) // see RULE_06
         || (s.ctrl[CTRL_PAR_EN] && !master && s.par2 && !s.par_d);
    n.dsg_en_d = s.ctrl[CTRL_DSG_EN];

    // Power state machine
    unique case (s.st)
      ST_OFF, ST_SLEEP: begin
        if (wake) begin
          n.st = ST_PRECHG; // see RULE_12
          n.pre_ms = 13'h0;
        end
      end
      ST_PRECHG: begin
        if (ms) begin
          n.pre_ms = s.pre_ms + 13'h1;
        end
        if (ms && (s.pre_ms + 13'h1 >= pre_lim)) begin
          n.st = ST_RUN; // see RULE_12
        end
      end
      ST_RUN: begin
        if (s.ctrl[CTRL_DSG_EN] && !s.dsg_en_d) begin
          n.st = ST_PRECHG; // see RULE_12
          n.pre_ms = 13'h0;
        end
        if (s.ctrl[CTRL_SLEEP_EN] && s.idle_ms >= 28'(IDLE_MS_P)) begin
          n.st = ST_SLEEP; // see RULE_03, RULE_07
        end
        if (s.uv_ms >= 16'(UV_MS_P)) begin
          n.st = ST_SLEEP; // see RULE_04
        end
      end
      ST_LEDSEQ: begin
        if (ms) begin
          n.seq_ms = s.seq_ms + 9'h1;
        end
        if (ms && s.seq_ms == 9'(LED_STEP_P - 1)) begin
          n.seq_ms = 9'h0;
          n.seq_idx = s.seq_idx + 3'h1; // see RULE_05
          if (s.seq_idx == 3'(LED_NUM - 1)) begin
            n.st = ST_SLEEP;
          end
        end
      end
    endcase
    if ((s.st == ST_RUN || s.st == ST_PRECHG)
        && s.btn_ms >= 13'(BTN_MS_P)) begin
      n.st = ST_LEDSEQ; // see RULE_05
      n.seq_ms = 9'h0;
      n.seq_idx = 3'h0;
    end
    // Shutdown requests override everything else
    if (s.ctrl[CTRL_EXT_SW] && !s.sw2) begin
      n.st = ST_OFF; // see RULE_06
    end
    if (s.ctrl[CTRL_PAR_EN] && !master && !s.par2 && s.par_d) begin
      n.st = ST_OFF; // see RULE_15
    end
    if (n.st == ST_SLEEP && s.st != ST_SLEEP) begin
      int_ev[INT_SLEEP] = 1'b1;
      n.idle_ms = 28'h0;
    end

    // Charge current limiting
    if (s.st != ST_RUN || !chg || s.ctrl[CTRL_LIM_ACT]) begin
      n.limited = 1'b0;
      n.lim_ms = 19'h0;
    end else if (!s.limited) begin
      if (chg_cur >= s.ocw) begin
        n.limited = 1'b1; // see RULE_14
        n.lim_ms = 19'h0;
        int_ev[INT_LIMIT] = 1'b1;
      end
    end else if (ms) begin
      n.lim_ms = s.lim_ms + 19'h1;
      if (s.lim_ms == 19'(LIMIT_MS_P - 1)) begin
        n.lim_ms = 19'h0; // see RULE_14
        n.limited = (chg_cur >= s.ocw); // see RULE_17
      end
    end

    // Indicators
    for (int i = 0; i < SOC_LEDS; i++) begin
      n.led[i] = (s.st == ST_RUN) && (soc > 7'(i * 25)); // see RULE_02
    end
    n.led[4] = (s.st == ST_RUN) && (fault || alarm_hit); // see RULE_02
    // Steady in standby, fast blink charging, slow blink discharging
    n.led[5] = (s.st == ST_RUN)
             && (chg ? s.sec_ms[7] : dsg ? s.sec_ms[9] : 1'b1);
    if (s.st == ST_LEDSEQ) begin
      for (int i = 0; i < LED_NUM; i++) begin
        n.led[i] = (3'(i) <= s.seq_idx); // see RULE_05
      end
    end

    // History capture
    ev = {short_hit, alarm_hit, prot_hit};
    n.ev_d = ev;
    n.st_d = s.st;
    if (s.st != s.st_d) begin
      cause[0] = 1'b1; // see RULE_10
    end
    if (ev != s.ev_d) begin
      cause[1] = 1'b1; // see RULE_10
    end
    if (sec && s.rec_intv != 16'h0 && s.time_s >= s.rec_start
        && s.time_s <= s.rec_end) begin
      n.rec_s = s.rec_s + 16'h1;
      if (s.rec_s + 16'h1 >= s.rec_intv) begin
        n.rec_s = 16'h0;
        cause[2] = 1'b1; // see RULE_10
      end
    end
    rec_we = |cause;
    if (rec_we) begin
      n.hist_wp = (s.hist_wp == AW'(HIST_DEPTH - 1)) ? '0 : s.hist_wp + 1'b1;
      if (s.hist_cnt != (AW + 1)'(HIST_DEPTH)) begin
        n.hist_cnt = s.hist_cnt + 1'b1;
      end
    end

    // APB slave
    setup = psel && !penable;
    access = psel && penable;
    if (setup) begin
      n.rerr = 1'b0;
      n.rdata = 32'h0;
      unique case (paddr)
        OFS_CTRL:      n.rdata = 32'(s.ctrl);
        OFS_FULL_CAP:  n.rdata = 32'(s.full_cap);
        OFS_BAL_START: n.rdata = 32'(s.bal_start);
        OFS_BAL_DIFF:  n.rdata = 32'(s.bal_diff);
        OFS_PRECHG:    n.rdata = 32'(s.pre_set);
        OFS_OCW:       n.rdata = 32'(s.ocw);
        OFS_REC_START: n.rdata = 32'(s.rec_start);
        OFS_REC_END:   n.rdata = 32'(s.rec_end);
        OFS_REC_INTV:  n.rdata = 32'(s.rec_intv);
        OFS_STATUS:    n.rdata = {8'h0, s.addr2, 5'h0, s.st, 2'h0,
                                  bal_on, fault, s.limited, dsg, chg,
                                  power_on};
        OFS_CYCLES:    n.rdata = 32'(s.cycles);
        OFS_INT_STAT:  n.rdata = 32'(s.int_stat);
        OFS_INT_MASK:  n.rdata = 32'(s.int_mask);
        OFS_HIST_IDX:  n.rdata = {8'h0, 8'(s.hist_cnt), 8'h0,
                                  8'(s.hist_idx)};
        OFS_HIST_DATA: n.rdata = hist_mem[s.hist_idx];
        OFS_TIME:      n.rdata = 32'(s.time_s);
        default:       n.rerr = 1'b1;
      endcase
    end
    if (access && pwrite) begin
      unique case (paddr)
        OFS_CTRL:      n.ctrl = pwdata[11:0]; // see RULE_07, RULE_11
        OFS_FULL_CAP:  n.full_cap = pwdata[15:0];
        OFS_BAL_START: n.bal_start = pwdata[15:0]; // see RULE_08
        OFS_BAL_DIFF:  n.bal_diff = pwdata[15:0]; // see RULE_08
        OFS_PRECHG:    n.pre_set = pwdata[12:0]; // see RULE_12
        OFS_OCW:       n.ocw = pwdata[15:0];
        OFS_REC_START: n.rec_start = pwdata[19:0];
        OFS_REC_END:   n.rec_end = pwdata[19:0];
        OFS_REC_INTV:  n.rec_intv = pwdata[15:0];
        OFS_INT_MASK:  n.int_mask = pwdata[3:0];
        OFS_HIST_IDX:  n.hist_idx = pwdata[AW-1:0];
        default: ;
      endcase
    end
    rd_clr = access && !pwrite && (paddr == OFS_INT_STAT);
    // A new event in the clearing cycle survives
    n.int_stat = (rd_clr ? 4'h0 : s.int_stat) | int_ev;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.full_cap <= FULL_CAP_RST;
      s.bal_start <= BAL_START_RST;
      s.bal_diff <= BAL_DIFF_RST;
      s.pre_set <= PRECHG_RST;
      s.ocw <= OCW_RST;
      s.rec_end <= 20'hfffff;
      s.st <= ST_PRECHG;
      s.st_d <= ST_PRECHG;
    end else begin
      s <= n;
    end
  end

  // Record: time, cause, state, raw event vector
  always_ff @(posedge core_clk) begin
    if (rec_we) begin
      hist_mem[s.hist_wp] <= {s.time_s, cause, s.st, ev}; // see RULE_10
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cell_dif = cell_max - cell_min;
  assign pready = 1'b1;
  assign prdata = s.rdata;
  assign pslverr = access && s.rerr;
  assign power_on = (s.st != ST_OFF) && (s.st != ST_SLEEP);
  // Link stays up through the undervoltage hold
  assign comm_en = power_on; // see RULE_04
  assign precharge_on = (s.st == ST_PRECHG);
  assign dsg_sw_on = (s.st == ST_RUN) && s.ctrl[CTRL_DSG_EN] && !fault;
  assign limit_on = (s.st == ST_RUN) && chg && !fault
                 && (s.ctrl[CTRL_LIM_ACT] || s.limited); // see RULE_13
  assign main_chg_on = (s.st == ST_RUN) && !fault
                    && !s.ctrl[CTRL_LIM_ACT] && !s.limited; // see RULE_14
  assign bal_on = (s.st == ST_RUN) && s.ctrl[CTRL_BAL_EN] && !dsg
               && cell_max >= s.bal_start
               && cell_max >= cell_min
               && cell_dif >= s.bal_diff; // see RULE_08
  assign par_cmd_out = s.ctrl[CTRL_PAR_EN] && master
                    && power_on; // see RULE_15
  assign comm_addr = s.addr2; // see RULE_09
  assign led = s.led;
  assign baud_tick = s.baud;
  assign irq = |(s.int_stat & s.int_mask);

endmodule
`default_nettype wire

//--- rtl/bps_pkg.sv
package bps_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned BAUD_RATE      = 19200;
  localparam int unsigned BAUD_CYC       =
    1000000000 / (CLK_PERIOD_NS * BAUD_RATE);
  localparam int unsigned IDLE_SLEEP_H   = 48;
  localparam int unsigned IDLE_SLEEP_MS  = IDLE_SLEEP_H * 3600 * 1000;
  localparam int unsigned UV_HOLD_MIN    = 1;
  localparam int unsigned UV_HOLD_MS     = UV_HOLD_MIN * 60000;
  localparam int unsigned BTN_HOLD_S     = 6;
  localparam int unsigned BTN_HOLD_MS    = BTN_HOLD_S * 1000;
  localparam int unsigned LIMIT_MIN      = 5;
  localparam int unsigned LIMIT_MS       = LIMIT_MIN * 60000;
  localparam int unsigned LED_STEP_MS    = 500;
  localparam int unsigned SEC_MS         = 1000;
  localparam logic [12:0] PRECHG_MIN_MS  = 13'h0001;
  localparam logic [12:0] PRECHG_MAX_MS  = 13'h1388;

  // ----------------------------------------------------------------
  // Fixed quantities
  // ----------------------------------------------------------------
  localparam logic [18:0] CYCLE_DIV   = 19'h00005;
  localparam logic [15:0] CUR_IDLE    = 16'h000a;
  localparam int unsigned LED_NUM     = 6;
  localparam int unsigned SOC_LEDS    = 4;
  localparam int unsigned HIST_MIN    = 300;
  localparam logic [7:0]  MASTER_ADDR = 8'h00;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_FULL_CAP  = 8'h04;
  localparam logic [7:0] OFS_BAL_START = 8'h08;
  localparam logic [7:0] OFS_BAL_DIFF  = 8'h0c;
  localparam logic [7:0] OFS_PRECHG    = 8'h10;
  localparam logic [7:0] OFS_OCW       = 8'h14;
  localparam logic [7:0] OFS_REC_START = 8'h18;
  localparam logic [7:0] OFS_REC_END   = 8'h1c;
  localparam logic [7:0] OFS_REC_INTV  = 8'h20;
  localparam logic [7:0] OFS_STATUS    = 8'h24;
  localparam logic [7:0] OFS_CYCLES    = 8'h28;
  localparam logic [7:0] OFS_INT_STAT  = 8'h2c;
  localparam logic [7:0] OFS_INT_MASK  = 8'h30;
  localparam logic [7:0] OFS_HIST_IDX  = 8'h34;
  localparam logic [7:0] OFS_HIST_DATA = 8'h38;
  localparam logic [7:0] OFS_TIME      = 8'h3c;

  // CTRL fields
  localparam int unsigned CTRL_SLEEP_EN = 0;
  localparam int unsigned CTRL_EXT_SW   = 1;
  localparam int unsigned CTRL_LIM_ACT  = 2;
  localparam int unsigned CTRL_BAL_EN   = 3;
  localparam int unsigned CTRL_DSG_EN   = 4;
  localparam int unsigned CTRL_PAR_EN   = 5;
  localparam int unsigned CTRL_PROT_LSB = 8;

  // Interrupt bits
  localparam int unsigned INT_CYCLE = 0;
  localparam int unsigned INT_SLEEP = 1;
  localparam int unsigned INT_FAULT = 2;
  localparam int unsigned INT_LIMIT = 3;

  // Reset values
  localparam logic [11:0] CTRL_RST      = 12'hf19;
  localparam logic [15:0] FULL_CAP_RST  = 16'h07d0;
  localparam logic [15:0] BAL_START_RST = 16'h0d48;
  localparam logic [15:0] BAL_DIFF_RST  = 16'h001e;
  localparam logic [12:0] PRECHG_RST    = 13'h01f4;
  localparam logic [15:0] OCW_RST       = 16'h07d0;

  typedef enum logic [2:0] {
    ST_OFF, ST_PRECHG, ST_RUN, ST_LEDSEQ, ST_SLEEP
  } bps_state_t;

endpackage

//--- tb/bps_props.sv
`timescale 1ns/1ps
`default_nettype none
module bps_props
  import bps_pkg::*;
#(
  parameter int unsigned BAUD_CYC_P = 20
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pslverr,
  input wire logic [7:0]  addr_sw,
  input wire logic [7:0]  comm_addr,
  input wire logic [15:0] dsg_cur,
  input wire logic        power_on,
  input wire logic        comm_en,
  input wire logic        precharge_on,
  input wire logic        dsg_sw_on,
  input wire logic        main_chg_on,
  input wire logic        limit_on,
  input wire logic        bal_on,
  input wire logic        baud_tick
);
  logic [15:0] bcnt_reg;
  logic        seen_reg;
  logic [2:0]  age_reg;
  // Gap is unknown before the first tick
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bcnt_reg <= 16'h0000;
      seen_reg <= 1'b0;
      age_reg  <= 3'h0;
    end else begin
      bcnt_reg <= baud_tick ? 16'h0000 : bcnt_reg + 16'h0001;
      seen_reg <= seen_reg | baud_tick;
      age_reg  <= (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Synchroniser needs a few edges after reset
  sequence sync_settled;
    (age_reg == 3'h7) ##0 $stable(addr_sw) [*4];
  endsequence
  sequence wake_up;
    $rose(power_on);
  endsequence
  comm_alive_a: assert property (comm_en == power_on)
    else $error("comm enable differs from power state");
  bal_window_a: assert property (bal_on |-> dsg_cur <= CUR_IDLE)
    else $error("balancing while discharging");
  path_excl_a: assert property (!(limit_on && main_chg_on))
    else $error("both charge paths on");
  baud_gap_a: assert property (baud_tick |=> !baud_tick [*8])
    else $error("baud ticks too close");
  baud_period_a: assert property (seen_reg |->
    bcnt_reg < BAUD_CYC_P && (!baud_tick || bcnt_reg == BAUD_CYC_P - 1))
    else $error("baud period wrong");
  addr_follow_a: assert property (sync_settled |-> comm_addr == addr_sw)
    else $error("address not taken from switch");
  wake_pre_a: assert property (wake_up |-> precharge_on)
    else $error("power up without precharge");
  off_quiet_a: assert property (!power_on |->
    !(dsg_sw_on || main_chg_on || limit_on || bal_on))
    else $error("switch on while shut down");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule
bind bps_top bps_props #(.BAUD_CYC_P(BAUD_CYC_P)) u_props (
  .core_clk, .rst, .psel, .penable, .pslverr, .addr_sw, .comm_addr,
  .dsg_cur, .power_on, .comm_en, .precharge_on, .dsg_sw_on,
  .main_chg_on, .limit_on, .bal_on, .baud_tick
);
`default_nettype wire

//--- tb/bps_panel.sv
`timescale 1ns/1ps
`default_nettype none
module bps_panel #(
  parameter int unsigned MS_CYC = 10
) (
  input  wire logic core_clk,
  output logic      reset_btn,
  output logic      ext_sw,
  output logic      par_cmd_in
);
  initial begin
    reset_btn = 1'b0;
    ext_sw = 1'b1;
    par_cmd_in = 1'b1;
  end
  // Operator must keep the button down the whole count
  task automatic hold(input int ms);
    @(posedge core_clk);
    reset_btn <= !reset_btn;
    repeat (ms * MS_CYC) @(posedge core_clk);
    reset_btn <= 1'b0;
  endtask
  task automatic sw(input logic on);
    @(posedge core_clk);
    ext_sw <= on;
  endtask
  task automatic master(input logic on);
    @(posedge core_clk);
    par_cmd_in <= on;
  endtask
endmodule
`default_nettype wire

//--- tb/bps_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module bps_top_test;
  import bps_pkg::*;
  typedef struct {
    logic        rd;
    logic [31:0] m;
    logic [31:0] e;
    string       nm;
  } bps_note_t;
  logic        core_clk, rst, psel, penable, pwrite, chk, cap_tick;
  logic        pready, pslverr, reset_btn, ext_sw, par_cmd_in, uv_prot;
  logic        short_hit, alarm_hit, power_on, comm_en, irq, bal_on;
  logic        precharge_on, dsg_sw_on, main_chg_on, limit_on;
  logic        par_cmd_out, baud_tick;
  logic [7:0]  paddr, addr_sw, comm_addr, a;
  logic [31:0] pwdata, prdata, outs, v;
  logic [15:0] chg_cur, dsg_cur, cell_max, cell_min;
  logic [6:0]  soc, s;
  logic [3:0]  prot_hit;
  logic [5:0]  led;
  int          n_mismatch = 0, tests_run = 0;
  int          cyc = 0;
  bps_note_t   q[$];
  bps_note_t   n;
  logic [6:0]  stbl [4] = '{7'h00, 7'h19, 7'h1a, 7'h64};
  logic [7:0]  ra [9] = '{OFS_CTRL, OFS_FULL_CAP, OFS_BAL_START,
    OFS_BAL_DIFF, OFS_PRECHG, OFS_OCW, OFS_REC_END, OFS_INT_MASK, 8'h40};
  logic [31:0] rv [9] = '{32'h0f19, 32'h07d0, 32'h0d48, 32'h001e,
    32'h01f4, 32'h07d0, 32'hfffff, 32'h0, 32'h0};
  assign outs = {17'h00000, comm_en, par_cmd_out, irq, bal_on, limit_on,
                 main_chg_on, dsg_sw_on, precharge_on, power_on, led};
  bps_top #(
    .TICK_CYC_P(10), .BAUD_CYC_P(20), .IDLE_MS_P(300), .UV_MS_P(100),
    .BTN_MS_P(60), .LIMIT_MS_P(50), .LED_STEP_P(5), .SEC_MS_P(10)
  ) DUT (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .reset_btn, .ext_sw, .addr_sw, .par_cmd_in,
    .chg_cur, .dsg_cur, .cap_tick, .soc, .cell_max, .cell_min, .prot_hit,
    .uv_prot, .short_hit, .alarm_hit, .led, .power_on, .comm_en,
    .precharge_on, .dsg_sw_on, .main_chg_on, .limit_on, .bal_on,
    .par_cmd_out, .comm_addr, .baud_tick, .irq
  );
  bps_panel #(.MS_CYC(10)) P (.core_clk, .reset_btn, .ext_sw, .par_cmd_in);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= !penable;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge core_clk);
    penable <= psel;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] m, e,
                    input string nm);
    q.push_back('{1'b1, m, e, nm});
    apb(1'b0, ad, 32'h0);
  endtask
  task automatic pin(input logic [31:0] m, e, input string nm);
    q.push_back('{1'b0, m, e, nm});
    @(posedge core_clk);
    chk <= 1'b1;
    @(posedge core_clk);
    chk <= 1'b0;
  endtask
  task automatic ms(input int k);
    repeat (k * 10) @(posedge core_clk);
  endtask
  task automatic settle;
    repeat (5) @(posedge core_clk);
  endtask
  task automatic cur(input logic [15:0] c, d);
    chg_cur <= c + 16'($urandom_range(9, 0));
    dsg_cur <= d + 16'($urandom_range(9, 0));
    settle();
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Notes queue in issue order; reads are judged at their access edge
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (chk || (psel && penable && pready === 1'b1 && !pwrite)) begin
      n = q.pop_front();
      v = n.rd ? prdata : outs;
      tests_run++;
      if ((v & n.m) !== n.e) begin
        $display("ERROR %s expected %h seen %h", n.nm, n.e, v & n.m);
        n_mismatch++;
      end
    end
    if (cyc == 30000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    {psel, penable, pwrite, chk, cap_tick, uv_prot} = 6'h00;
    {short_hit, alarm_hit, rst} = 3'h1;
    {paddr, pwdata, addr_sw, prot_hit} = {8'h00, 32'h0, 8'h01, 4'h0};
    {chg_cur, dsg_cur} = {16'h0000, 16'h0032};
    {cell_max, cell_min, soc} = {16'h0d48, 16'h0d48, 7'h32};
    void'($urandom(32'heb4f2dcf));
    repeat (4) @(posedge core_clk);
    rst <= !rst;
    for (int i = 0; i < 9; i++) rd(ra[i], 32'hffffffff, rv[i], "reg");
    pin(32'hc0, 32'hc0, "pre start");
    ms(470);
    pin(32'h80, 32'h80, "pre hold");
    ms(40);
    pin(32'h1c0, 32'h140, "pre end");
    wr(OFS_CTRL, 32'h0f18);
    wr(OFS_PRECHG, 32'h0002);
    wr(OFS_FULL_CAP, 32'h000a);
    wr(OFS_INT_MASK, 32'h0005);
    rd(OFS_CYCLES, 32'hffff, 32'h0, "cycles");
    repeat (10) begin
      @(posedge core_clk);
      cap_tick <= !cap_tick;
      @(posedge core_clk);
      cap_tick <= 1'b0;
    end
    pin(32'h1000, 32'h1000, "irq");
    rd(OFS_INT_STAT, 32'h1, 32'h1, "cycle int");
    pin(32'h1000, 32'h0, "irq clr");
    rd(OFS_CYCLES, 32'hffff, 32'h5, "cycles");
    for (int i = 0; i < 5; i++) begin
      s = (i < 4) ? stbl[i] : 7'($urandom_range(100, 0));
      soc <= s;
      alarm_hit <= s[0];
      settle();
      pin(32'h1f, {27'h0, s[0], s > 75, s > 50, s > 25, s > 0}, "soc");
    end
    alarm_hit <= 1'b0;
    wr(OFS_CTRL, 32'h0018);
    prot_hit <= 4'($urandom_range(15, 1));
    settle();
    pin(32'h10, 32'h0, "prot off");
    short_hit <= !short_hit;
    settle();
    pin(32'h1110, 32'h1010, "short");
    rd(OFS_INT_STAT, 32'h4, 32'h4, "fault int");
    short_hit <= 1'b0;
    prot_hit <= 4'h0;
    wr(OFS_CTRL, 32'h0f18);
    cell_max <= 16'h0dac + 16'($urandom_range(99, 0));
    cell_min <= 16'h0d7a;
    cur(16'h0, 16'h0);
    pin(32'h800, 32'h800, "bal idle");
    cur(16'h0, 16'h0032);
    pin(32'h800, 32'h0, "bal dsg");
    cur(16'h0032, 16'h0);
    pin(32'h800, 32'h800, "bal chg");
    wr(OFS_OCW, 32'h0064);
    pin(32'h600, 32'h200, "main");
    cur(16'h0096, 16'h0);
    pin(32'h600, 32'h400, "limit");
    cur(16'h0032, 16'h0);
    ms(20);
    pin(32'h600, 32'h400, "limit held");
    ms(40);
    pin(32'h600, 32'h200, "main back");
    wr(OFS_CTRL, 32'h0f1c);
    pin(32'h600, 32'h400, "active");
    wr(OFS_CTRL, 32'h0f38);
    cur(16'h0, 16'h0);
    a = 8'($urandom_range(255, 1));
    addr_sw <= a;
    settle();
    rd(OFS_STATUS, 32'hff0000, {8'h0, a, 16'h0}, "addr");
    P.master(1'b0);
    settle();
    pin(32'h40, 32'h0, "slave off");
    P.master(1'b1);
    settle();
    pin(32'h40, 32'h40, "slave on");
    addr_sw <= 8'h00;
    ms(5);
    pin(32'h2000, 32'h2000, "master");
    wr(OFS_CTRL, 32'h0f1a);
    P.sw(1'b0);
    settle();
    pin(32'h40, 32'h0, "sw open");
    P.sw(1'b1);
    settle();
    pin(32'hc0, 32'hc0, "sw closed");
    ms(5);
    wr(OFS_CTRL, 32'h0f18);
    P.hold(70);
    ms(12);
    pin(32'h4f, 32'h4f, "chase");
    ms(23);
    pin(32'h40, 32'h0, "btn sleep");
    P.hold(2);
    settle();
    pin(32'h40, 32'h40, "wake");
    ms(5);
    uv_prot <= !uv_prot;
    ms(90);
    pin(32'h4040, 32'h4040, "uv comm");
    ms(20);
    pin(32'h4040, 32'h0, "uv sleep");
    uv_prot <= 1'b0;
    P.hold(2);
    ms(5);
    wr(OFS_CTRL, 32'h0f19);
    ms(320);
    pin(32'h40, 32'h0, "idle");
    summarize();
  end
endmodule
`default_nettype wire
